// File: core/bfq_pkg.sv
`default_nettype none

package bfq_pkg;

	// Word and byte layout of both ports
	localparam int DATA_W = 36;
	localparam int BYTE_W = 9;
	localparam int BYTES = 4;
	localparam int PAR_BIT = 8;

	// Queue geometry and almost-flag offset
	localparam int FIFO_DEPTH = 8;
	localparam int ALMOST_X = 2;

	// Flag vector positions, all active low
	localparam int FLG_EMPTY = 0;
	localparam int FLG_ALMOST_EMPTY = 1;
	localparam int FLG_FULL = 2;
	localparam int FLG_ALMOST_FULL = 3;

	// Reset values
	localparam logic [3:0] FLAGS_RST = 4'hc;
	localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
	localparam logic MBX_FULL_N_RST = 1'b1;

	// Control pins of one port
	typedef struct packed {
		logic select_n;
		logic write_not_read;
		logic enable;
		logic mailbox_select;
		logic parity_gen_select;
	} bfq_ctl_t;

	// Everything one port presents at its pins
	typedef struct packed {
		logic clock;
		bfq_ctl_t ctl;
		logic [DATA_W-1:0] data;
	} bfq_pins_t;

	localparam bfq_ctl_t CTL_RST = 5'h10;
	localparam bfq_pins_t PINS_RST = '{1'b0, CTL_RST, DATA_RST};

	// Parity of the lower eight bits of each byte
	function automatic logic [BYTES-1:0] bfq_low_par(input logic [DATA_W-1:0] d);
		for (int b = 0; b < BYTES; b++) begin
			bfq_low_par[b] = ^d[b*BYTE_W +: PAR_BIT];
		end
	endfunction : bfq_low_par

	// Substitute generated bits for each byte's top bit
	function automatic logic [DATA_W-1:0] bfq_put_par(input logic [DATA_W-1:0] d,
			input logic [BYTES-1:0] lp, input logic odd);
		bfq_put_par = d;
		for (int b = 0; b < BYTES; b++) begin
			bfq_put_par[b*BYTE_W+PAR_BIT] = lp[b] ^ odd;
		end
	endfunction : bfq_put_par

endpackage : bfq_pkg

`default_nettype wire

// File: core/bfq_bidir.sv
`default_nettype none

// Queue of flip-flops with valid/ready on both sides
module bfq_fifo #(
	parameter int W = 36,
	parameter int D = 8,
	parameter int CW = $clog2(D + 1)
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [W-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [W-1:0] rd_data,
	output logic [CW-1:0] count
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW-1:0] LAST = AW'(D - 1);

	logic [W-1:0] mem_r [D];
	logic [W-1:0] mem_nxt [D];
	logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
	logic [CW-1:0] count_r, count_nxt;
	logic do_wr, do_rd;

	// Honest full and empty from the occupancy count
	// The count runs from 0 to D, one value more than the pointers, so full and empty never alias
	assign wr_ready = (count_r != CW'(D));
	assign rd_valid = (count_r != '0);
	assign rd_data = mem_r[rd_ptr_r];
	assign count = count_r;
	assign do_wr = wr_valid & wr_ready;
	assign do_rd = rd_valid & rd_ready;

	// Pointer, storage and count update
	// A write and a read in one cycle leave the count unchanged
	always_comb begin
		mem_nxt = mem_r;
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		count_nxt = count_r;
		if (do_wr) begin
			mem_nxt[wr_ptr_r] = wr_data;
			wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
		end
		if (do_rd) begin
			rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
		end
		if (do_wr && !do_rd) begin
			count_nxt = count_r + 1'b1;
		end else if (do_rd && !do_wr) begin
			count_nxt = count_r - 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_r <= '{default: '0};
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r <= count_nxt;
		end
	end
endmodule : bfq_fifo

// Bidirectional queue pair with mailboxes and parity, on one system clock
module bfq_bidir #(
	parameter int FIFO_DEPTH = bfq_pkg::FIFO_DEPTH,
	parameter int ALMOST_X = bfq_pkg::ALMOST_X
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic odd_even_select,
	input wire logic port_a_clock,
	input wire logic port_a_select_n,
	input wire logic port_a_write_not_read,
	input wire logic port_a_enable,
	input wire logic port_a_mailbox_select,
	input wire logic port_a_parity_gen_select,
	input wire logic [bfq_pkg::DATA_W-1:0] port_a_data_in,
	output logic [bfq_pkg::DATA_W-1:0] port_a_data_out,
	output logic port_a_data_oe,
	output logic port_a_empty_n,
	output logic port_a_almost_empty_n,
	output logic port_a_full_n,
	output logic port_a_almost_full_n,
	output logic port_a_parity_error_n,
	output logic a_to_b_mailbox_full_n,
	input wire logic port_b_clock,
	input wire logic port_b_select_n,
	input wire logic port_b_write_not_read,
	input wire logic port_b_enable,
	input wire logic port_b_mailbox_select,
	input wire logic port_b_parity_gen_select,
	input wire logic [bfq_pkg::DATA_W-1:0] port_b_data_in,
	output logic [bfq_pkg::DATA_W-1:0] port_b_data_out,
	output logic port_b_data_oe,
	output logic port_b_empty_n,
	output logic port_b_almost_empty_n,
	output logic port_b_full_n,
	output logic port_b_almost_full_n,
	output logic port_b_parity_error_n,
	output logic b_to_a_mailbox_full_n
);
	import bfq_pkg::*;

	localparam int CW = $clog2(FIFO_DEPTH + 1);

	// Index 0 is port A (a_to_b queue and mailbox), index 1 is port B
	bfq_pins_t pins_in [2];
	bfq_pins_t s1_r [2];
	bfq_pins_t s2_r [2];
	logic [1:0] clk_d_r;
	logic odd1_r, odd2_r;
	logic [DATA_W-1:0] mbx_r [2];
	logic [DATA_W-1:0] mbx_nxt [2];
	logic [1:0] mbx_full_n_r, mbx_full_n_nxt;
	logic [DATA_W-1:0] dout_r [2];
	logic [DATA_W-1:0] dout_nxt [2];
	logic [1:0] oe_r, oe_nxt, pe_n_r, pe_n_nxt;
	logic [3:0] fs1_r [2];
	logic [3:0] fs1_nxt [2];
	logic [3:0] fs2_r [2];
	logic [3:0] fs2_nxt [2];
	logic [1:0] mbx_rd, q_wr_valid, q_wr_ready, q_rd_valid, q_rd_ready;
	logic [DATA_W-1:0] q_rd_data [2];
	logic [CW-1:0] q_count [2];

	// Gather pins of each port into one carrier
	// All pins of a port pass the same two stages, so control and data stay aligned
	assign pins_in[0] = '{port_a_clock, '{port_a_select_n, port_a_write_not_read,
		port_a_enable, port_a_mailbox_select, port_a_parity_gen_select}, port_a_data_in};
	assign pins_in[1] = '{port_b_clock, '{port_b_select_n, port_b_write_not_read,
		port_b_enable, port_b_mailbox_select, port_b_parity_gen_select}, port_b_data_in};

	// Shared odd/even select through two flip-flops
	// A change takes effect two system clocks later, for all bytes of a word together
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			odd1_r <= 1'b0;
			odd2_r <= 1'b0;
		end else begin
			odd1_r <= odd_even_select;
			odd2_r <= odd1_r;
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam int O = 1 - p;
		bfq_ctl_t ctl;
		logic clk_rise, sel, wr, rd, mbx_wr, gen_mbx;
		logic [DATA_W-1:0] tree_in;
		logic [BYTES-1:0] lp, err;
		logic [3:0] raw;

		// Port decode on the synchronised port clock rising edge
		// Each port clock level must last one system clock, or its edge is missed
		assign ctl = s2_r[p].ctl;
		assign clk_rise = s2_r[p].clock & ~clk_d_r[p];
		assign sel = ~ctl.select_n & ctl.enable;
		assign wr = clk_rise & sel & ctl.write_not_read;
		assign rd = clk_rise & sel & ~ctl.write_not_read;
		assign mbx_wr = wr & ctl.mailbox_select;
		assign mbx_rd[p] = rd & ctl.mailbox_select;
		assign q_wr_valid[p] = wr & ~ctl.mailbox_select;
		assign q_rd_ready[O] = rd & ~ctl.mailbox_select;

		// One shared parity tree per port, checking inputs or generating mailbox parity; queue-read parity uses a second tree
		// Sharing the tree leaves the input check blind while mailbox parity is made
		assign gen_mbx = sel & ~ctl.write_not_read & ctl.mailbox_select
			& ctl.parity_gen_select;
		assign tree_in = gen_mbx ? mbx_r[O] : s2_r[p].data;
		assign lp = bfq_low_par(tree_in);
		for (genvar b = 0; b < BYTES; b++) begin : g_byte
			assign err[b] = lp[b] ^ tree_in[b*BYTE_W+PAR_BIT] ^ odd2_r;
		end

		// Raw queue levels: read side from queue O, write side from queue p
		// These follow the count at once; the filters below slow only the rising side
		assign raw[FLG_EMPTY] = (q_count[O] != '0);
		assign raw[FLG_ALMOST_EMPTY] = (q_count[O] > CW'(ALMOST_X));
		assign raw[FLG_FULL] = (q_count[p] != CW'(FIFO_DEPTH));
		assign raw[FLG_ALMOST_FULL] = (q_count[p] < CW'(FIFO_DEPTH - ALMOST_X));

		// Next state of mailbox, output word, flags and parity error
		// A mailbox write is taken only while the mailbox is empty, so one that meets a far read of full mail is lost
		always_comb begin
			mbx_nxt[p] = mbx_r[p];
			mbx_full_n_nxt[p] = mbx_full_n_r[p];
			if (mbx_rd[O]) begin
				mbx_full_n_nxt[p] = 1'b1;
			end
			if (mbx_wr && mbx_full_n_r[p]) begin
				mbx_nxt[p] = s2_r[p].data;
				mbx_full_n_nxt[p] = 1'b0;
			end
			dout_nxt[p] = dout_r[p];
			if (mbx_rd[p]) begin
				dout_nxt[p] = ctl.parity_gen_select
					? bfq_put_par(mbx_r[O], lp, odd2_r) : mbx_r[O];
			end else if (q_rd_ready[O] && q_rd_valid[O]) begin
				dout_nxt[p] = ctl.parity_gen_select ? bfq_put_par(q_rd_data[O],
					bfq_low_par(q_rd_data[O]), odd2_r) : q_rd_data[O];
			end
			oe_nxt[p] = sel & ~ctl.write_not_read;
			pe_n_nxt[p] = gen_mbx | ~(|err);
			// Falls at once, rises after two port-clock edges
			fs1_nxt[p] = raw & (fs1_r[p] | {4{clk_rise}});
			fs2_nxt[p] = raw & (clk_rise ? fs1_r[p] : fs2_r[p]);
		end

		// Pin synchronisers and port state registers
		// Reset values match an idle port: no access, no data driven, flags safe
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				s1_r[p] <= PINS_RST;
				s2_r[p] <= PINS_RST;
				clk_d_r[p] <= 1'b0;
				mbx_r[p] <= DATA_RST;
				mbx_full_n_r[p] <= MBX_FULL_N_RST;
				dout_r[p] <= DATA_RST;
				oe_r[p] <= 1'b0;
				pe_n_r[p] <= 1'b1;
				fs1_r[p] <= FLAGS_RST;
				fs2_r[p] <= FLAGS_RST;
			end else begin
				s1_r[p] <= pins_in[p];
				s2_r[p] <= s1_r[p];
				clk_d_r[p] <= s2_r[p].clock;
				mbx_r[p] <= mbx_nxt[p];
				mbx_full_n_r[p] <= mbx_full_n_nxt[p];
				dout_r[p] <= dout_nxt[p];
				oe_r[p] <= oe_nxt[p];
				pe_n_r[p] <= pe_n_nxt[p];
				fs1_r[p] <= fs1_nxt[p];
				fs2_r[p] <= fs2_nxt[p];
			end
		end

		// Queue p is filled by port p and drained by port O
		// Depth is a parameter; the flags scale with it and with the almost offset
		bfq_fifo #(
			.W(DATA_W),
			.D(FIFO_DEPTH),
			.CW(CW)
		) u_queue (
			.clk(mclk),
			.rst_b(rst_b),
			.wr_valid(q_wr_valid[p]),
			.wr_ready(q_wr_ready[p]),
			.wr_data(s2_r[p].data),
			.rd_valid(q_rd_valid[p]),
			.rd_ready(q_rd_ready[p]),
			.rd_data(q_rd_data[p]),
			.count(q_count[p])
		);
	end

	// Port A outputs
	// Full is also gated by queue ready so it never reads high while writes are refused
	assign port_a_data_out = dout_r[0];
	assign port_a_data_oe = oe_r[0];
	assign port_a_empty_n = fs2_r[0][FLG_EMPTY];
	assign port_a_almost_empty_n = fs2_r[0][FLG_ALMOST_EMPTY];
	assign port_a_full_n = fs2_r[0][FLG_FULL] & q_wr_ready[0];
	assign port_a_almost_full_n = fs2_r[0][FLG_ALMOST_FULL];
	assign port_a_parity_error_n = pe_n_r[0];
	assign a_to_b_mailbox_full_n = mbx_full_n_r[0];

	// Port B outputs
	assign port_b_data_out = dout_r[1];
	assign port_b_data_oe = oe_r[1];
	assign port_b_empty_n = fs2_r[1][FLG_EMPTY];
	assign port_b_almost_empty_n = fs2_r[1][FLG_ALMOST_EMPTY];
	assign port_b_full_n = fs2_r[1][FLG_FULL] & q_wr_ready[1];
	assign port_b_almost_full_n = fs2_r[1][FLG_ALMOST_FULL];
	assign port_b_parity_error_n = pe_n_r[1];
	assign b_to_a_mailbox_full_n = mbx_full_n_r[1];
endmodule : bfq_bidir

`default_nettype wire

// File: tb/bfq_bidir_asserts.sv
`default_nettype none

// Port-level checks on flags, mailbox and parity paths
module bfq_bidir_chk (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic odd_even_select,
	input wire logic port_a_clock,
	input wire logic port_a_select_n,
	input wire logic port_a_write_not_read,
	input wire logic port_a_enable,
	input wire logic port_a_mailbox_select,
	input wire logic port_a_parity_gen_select,
	input wire logic port_a_full_n,
	input wire logic port_a_almost_full_n,
	input wire logic port_a_parity_error_n,
	input wire logic a_to_b_mailbox_full_n,
	input wire logic port_b_clock,
	input wire logic port_b_select_n,
	input wire logic port_b_write_not_read,
	input wire logic port_b_enable,
	input wire logic port_b_mailbox_select,
	input wire logic port_b_parity_gen_select,
	input wire logic [bfq_pkg::DATA_W-1:0] port_b_data_out,
	input wire logic port_b_empty_n,
	input wire logic port_b_almost_empty_n,
	input wire logic port_b_parity_error_n
);
	timeunit 1ns;
	timeprecision 1ps;
	import bfq_pkg::*;
	logic [BYTES-1:0] par_b;
	logic wr_mb_a;
	logic rd_mb_a;
	logic rd_mb_b;
	// Selected mailbox accesses on each port
	assign wr_mb_a = !port_a_select_n && port_a_enable && port_a_write_not_read
		&& port_a_mailbox_select;
	assign rd_mb_a = !port_a_select_n && port_a_enable && !port_a_write_not_read
		&& port_a_mailbox_select;
	assign rd_mb_b = !port_b_select_n && port_b_enable && !port_b_write_not_read
		&& port_b_mailbox_select;
	// Nine-bit parity of each output byte on port B
	always_comb begin
		for (int i = 0; i < BYTES; i++) begin
			par_b[i] = ^port_b_data_out[i*BYTE_W +: BYTE_W];
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// Mailbox flag, parity and flag-rise relations
	property p_mbx_set;
		$fell(a_to_b_mailbox_full_n) |-> wr_mb_a;
	endproperty
	a_mbx_set: assert property (p_mbx_set) else $error("mailbox set");
	property p_mbx_clr;
		$rose(a_to_b_mailbox_full_n) |-> rd_mb_b;
	endproperty
	a_mbx_clr: assert property (p_mbx_clr) else $error("mailbox clear");
	property p_gen_par;
		$rose(a_to_b_mailbox_full_n) && port_b_parity_gen_select |-> par_b == {BYTES{odd_even_select}};
	endproperty
	a_gen_par: assert property (p_gen_par) else $error("parity gen");
	property p_pe_b;
		(rd_mb_b && port_b_parity_gen_select) [*5] |-> port_b_parity_error_n;
	endproperty
	a_pe_b: assert property (p_pe_b) else $error("pe b");
	property p_pe_a;
		(rd_mb_a && port_a_parity_gen_select) [*5] |-> port_a_parity_error_n;
	endproperty
	a_pe_a: assert property (p_pe_a) else $error("pe a");
	property p_empty;
		$rose(port_b_empty_n) |-> $past(port_b_clock, 3);
	endproperty
	a_empty: assert property (p_empty) else $error("empty rise");
	property p_full;
		$rose(port_a_full_n) |-> $past(port_a_clock, 3);
	endproperty
	a_full: assert property (p_full) else $error("full rise");
	property p_aempty;
		$rose(port_b_almost_empty_n) |-> $past(port_b_clock, 3);
	endproperty
	a_aempty: assert property (p_aempty) else $error("aempty rise");
	property p_afull;
		$rose(port_a_almost_full_n) |-> $past(port_a_clock, 3);
	endproperty
	a_afull: assert property (p_afull) else $error("afull rise");
endmodule : bfq_bidir_chk

bind bfq_bidir bfq_bidir_chk u_chk (.*);

`default_nettype wire

// File: tb/bfq_port_model.sv
`default_nettype none

// Processor on one port: one port clock pulse per access
module bfq_port_model (
	input wire logic mclk,
	output var bfq_pkg::bfq_pins_t pins
);
	timeunit 1ns;
	timeprecision 1ps;
	import bfq_pkg::*;
	initial pins = PINS_RST;
	// Set pins, raise clock, hold, lower clock, release
	task automatic access(input bfq_ctl_t c, input logic [DATA_W-1:0] d);
		pins.ctl <= c;
		pins.data <= d;
		repeat (2) @(posedge mclk);
		pins.clock <= 1'b1;
		repeat (4) @(posedge mclk);
		pins.clock <= 1'b0;
		repeat (4) @(posedge mclk);
		pins.ctl <= CTL_RST;
		pins.data <= ~d; // Released bus shows no stale value
		repeat (2) @(posedge mclk);
	endtask : access
endmodule : bfq_port_model

`default_nettype wire

// File: tb/bfq_bidir_tb.sv
`default_nettype none

// Random mailbox and queue traffic across both ports
module bfq_bidir_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bfq_pkg::*;
	localparam int D = 8;
	localparam bfq_ctl_t MW = 5'h0e;
	localparam bfq_ctl_t MR = 5'h06;
	localparam bfq_ctl_t MRP = 5'h07;
	localparam bfq_ctl_t QW = 5'h0c;
	localparam bfq_ctl_t QR = 5'h04;
	localparam bfq_ctl_t QRP = 5'h05;
	logic mclk, rst_b, odd_even_select;
	logic port_a_clock, port_a_select_n, port_a_write_not_read, port_a_enable;
	logic port_a_mailbox_select, port_a_parity_gen_select;
	logic port_b_clock, port_b_select_n, port_b_write_not_read, port_b_enable;
	logic port_b_mailbox_select, port_b_parity_gen_select;
	logic [DATA_W-1:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
	logic port_a_data_oe, port_a_empty_n, port_a_almost_empty_n, port_a_full_n;
	logic port_a_almost_full_n, port_a_parity_error_n, a_to_b_mailbox_full_n;
	logic port_b_data_oe, port_b_empty_n, port_b_almost_empty_n, port_b_full_n;
	logic port_b_almost_full_n, port_b_parity_error_n, b_to_a_mailbox_full_n;
	bfq_pins_t pa, pb;
	int fail_count, checks_done;
	integer seed;
	logic [DATA_W-1:0] q[$];
	logic [DATA_W-1:0] d;
	logic pg;
	logic [DATA_W-1:0] w;
	// Each model's pin bundle feeds its port
	assign {port_a_clock, port_a_select_n, port_a_write_not_read, port_a_enable,
		port_a_mailbox_select, port_a_parity_gen_select, port_a_data_in} = pa;
	assign {port_b_clock, port_b_select_n, port_b_write_not_read, port_b_enable,
		port_b_mailbox_select, port_b_parity_gen_select, port_b_data_in} = pb;
	bfq_bidir #(.FIFO_DEPTH(D), .ALMOST_X(2)) DUT (.*);
	bfq_port_model u_pa (.mclk(mclk), .pins(pa));
	bfq_port_model u_pb (.mclk(mclk), .pins(pb));
	// 200 MHz system clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	function automatic logic [DATA_W-1:0] rnd();
		rnd = DATA_W'({$random(seed), $random(seed)});
	endfunction : rnd
	// Expected word with generated bits in each byte's top bit
	function automatic logic [DATA_W-1:0] gen(input logic [DATA_W-1:0] w, input logic odd);
		gen = w;
		for (int b = 0; b < 4; b++) begin
			gen[b*9+8] = ^w[b*9 +: 8] ^ odd;
		end
	endfunction : gen
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// Cut a hung run short
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		seed = 32'h8b99;
		fail_count = 0;
		checks_done = 0;
		rst_b = 1'b0;
		odd_even_select = 1'b0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(port_b_empty_n, 1'b0);
		chk(port_a_full_n, 1'b1);
		// Mailbox under both parity senses, blocked rewrite included
		for (int odd = 0; odd < 2; odd++) begin
			odd_even_select <= odd[0];
			d = rnd();
			u_pa.access(MW, d);
			chk(a_to_b_mailbox_full_n, 1'b0);
			u_pa.access(MW, ~d);
			u_pb.access(MRP, rnd());
			chk(port_b_data_out, gen(d, odd[0]));
			chk(port_b_data_oe, 1'b1);
			chk(a_to_b_mailbox_full_n, 1'b1);
			u_pb.access(MR, rnd());
			chk(port_b_data_out, d);
			u_pb.access(MW, ~d);
			chk(b_to_a_mailbox_full_n, 1'b0);
			chk(port_b_data_oe, 1'b0);
			u_pa.access(MRP, rnd());
			chk(port_a_data_out, gen(~d, odd[0]));
			chk(b_to_a_mailbox_full_n, 1'b1);
		end
		// Fill the queue past full, then drain it with random parity
		repeat (D + 1) begin
			d = rnd();
			if (q.size() < D)
				q.push_back(d);
			u_pa.access(QW, d);
		end
		chk(port_a_full_n, 1'b0);
		chk(port_a_almost_full_n, 1'b0);
		// Idle port B clocks sync its flags while its input parity is checked
		w = gen(rnd(), 1'b1);
		u_pb.access(CTL_RST, w ^ 36'h800000000);
		chk(port_b_parity_error_n, 1'b0);
		u_pb.access(CTL_RST, w);
		chk(port_b_parity_error_n, 1'b1);
		chk(port_b_empty_n, 1'b1);
		chk(port_b_almost_empty_n, 1'b1);
		repeat (D) begin
			pg = 1'($random(seed));
			d = q.pop_front();
			u_pb.access(pg ? QRP : QR, rnd());
			chk(port_b_data_out, pg ? gen(d, 1'b1) : d);
		end
		chk(port_b_empty_n, 1'b0);
		// One word from port B to port A, idle port A clocks syncing flags
		d = rnd();
		u_pb.access(QW, d);
		chk(port_b_full_n, 1'b1);
		chk(port_b_almost_full_n, 1'b1);
		w = gen(rnd(), 1'b1);
		u_pa.access(CTL_RST, w);
		chk(port_a_parity_error_n, 1'b1);
		u_pa.access(CTL_RST, w ^ 36'h000000100);
		chk(port_a_parity_error_n, 1'b0);
		chk(port_a_full_n, 1'b1);
		chk(port_a_almost_full_n, 1'b1);
		chk(port_a_empty_n, 1'b1);
		chk(port_a_almost_empty_n, 1'b0);
		u_pa.access(QRP, rnd());
		chk(port_a_data_out, gen(d, 1'b1));
		chk(port_a_data_oe, 1'b1);
		chk(port_a_empty_n, 1'b0);
		tally_and_finish();
	end
endmodule : bfq_bidir_tb

`default_nettype wire
